// ### src/wsc_pkg.sv
// Purpose: Shared constants and types for the wiper save and end-scale block
// Assumes: 100 MHz clock on clk_in
// Notes:   Times are kept in their own unit; cycle counts derive from them
package wsc_pkg;

    // Clock rate
    localparam int unsigned CLK_HZ          = 100_000_000;

    // Documented times
    localparam int unsigned DEBOUNCE_MS     = 8;
    localparam int unsigned IDLE_SAVE_MS    = 1000;
    localparam int unsigned STORE_MS        = 20;

    // Derived cycle counts (debounce and idle are minimum times, so a little more; store busy lasts exactly the figure)
    localparam int unsigned DEBOUNCE_CYC    = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int unsigned IDLE_SAVE_CYC   = CLK_HZ / 1000 * IDLE_SAVE_MS;
    localparam int unsigned STORE_CYC       = CLK_HZ / 1000 * STORE_MS;

    // Counter width covers the longest interval
    localparam int unsigned CNT_W           = 27;

    // Wiper coding
    localparam int unsigned CODE_W          = 6;
    localparam int unsigned TAPS            = 64;
    localparam logic [CODE_W-1:0] CODE_ZERO = 6'h00;
    localparam logic [CODE_W-1:0] CODE_FULL = 6'h3f;
    localparam logic [CODE_W-1:0] CODE_MID  = 6'h20;

    // Position: code plus two extra end steps
    typedef enum logic [1:0] {
        WSC_POS_CODE,
        WSC_POS_BOTTOM,
        WSC_POS_TOP
    } wsc_pos_type;

    // Top-level sequencing
    typedef enum logic [1:0] {
        WSC_ST_STRAP,
        WSC_ST_RUN,
        WSC_ST_STORE
    } wsc_state_type;

endpackage

// ### src/wsc_deb_if.sv
// Purpose: Carries one debounced input between debouncer and control
// Assumes: Single clock domain
// Notes:   level is the filtered pin level, long_pulse marks a long active level
`timescale 1ns/100ps
interface wsc_deb_if;
    logic level;        // Synchronised level
    logic long_pulse;   // One cycle once active beyond the debounce time
    logic active;       // Active level held beyond the debounce time

    modport filt (output level, output long_pulse, output active);
    modport user (input level, input long_pulse, input active);
endinterface

// ### src/wsc_debounce.sv
// Purpose: Three-stage synchroniser and hold-time filter for one pin
// Assumes: Pin is asynchronous to clk_in
// Notes:   ACT_HIGH chooses which level counts as pressed
`timescale 1ns/100ps
module wsc_debounce
#(
    parameter bit          ACT_HIGH        = 1'b1,
    parameter int unsigned DEBOUNCE_CYCLES = wsc_pkg::DEBOUNCE_CYC
)
(
    // Clock and reset
    input  wire logic  clk_in,
    input  wire logic  rst_b_in,
    // Raw pin
    input  wire logic  pin_in,
    // Filtered result
    wsc_deb_if.filt    deb
);
    import wsc_pkg::*;

    typedef struct packed {
        logic [2:0]       sync;
        logic             level;
        logic [CNT_W-1:0] cnt;
        logic             long_pulse;
        logic             active;
    } wsc_deb_state_type;

    wsc_deb_state_type st_reg;
    wsc_deb_state_type st_next;

    // Change accepted once stages two and three agree; stage one feeds only stage two
    always_comb
    begin
        st_next            = st_reg;
        st_next.sync       = {st_reg.sync[1:0], pin_in};
        st_next.long_pulse = 1'b0;
        if (st_reg.sync[1] == st_reg.sync[2])
        begin
            st_next.level = st_reg.sync[2];
        end
        // Any bounce of two cycles or more restarts the hold count
        if (st_reg.level != ACT_HIGH)
        begin
            st_next.cnt    = '0;
            st_next.active = 1'b0;
        end
        else if (st_reg.cnt < CNT_W'(DEBOUNCE_CYCLES))
        begin
            st_next.cnt = st_reg.cnt + CNT_W'(1);
        end
        else if (!st_reg.active)
        begin
            st_next.active     = 1'b1;  // Held beyond the debounce time
            st_next.long_pulse = 1'b1;
        end
    end

    // Idle level after reset is inactive
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            st_reg       <= '0;
            st_reg.sync  <= {3{~ACT_HIGH}};
            st_reg.level <= ~ACT_HIGH;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign deb.level      = st_reg.level;
    assign deb.long_pulse = st_reg.long_pulse;
    assign deb.active     = st_reg.active;

endmodule

// ### src/wsc_top.sv
// Purpose: Wiper register with push-button steps, auto or manual save, end-scale flag
// Assumes: 100 MHz clk_in; save pin strap settled when reset releases
// Notes:   Store is modelled as a write strobe plus a fixed busy time
`timescale 1ns/100ps

module wsc_top
#(
    parameter int unsigned DEBOUNCE_CYCLES  = wsc_pkg::DEBOUNCE_CYC,
    parameter int unsigned IDLE_SAVE_CYCLES = wsc_pkg::IDLE_SAVE_CYC,
    parameter int unsigned STORE_CYCLES     = wsc_pkg::STORE_CYC,
    parameter logic [5:0]  POWERUP_CODE     = wsc_pkg::CODE_MID
)
(
    // Clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          rst_b_in,
    // Push buttons, active high
    input  wire logic                          step_up_button_in,
    input  wire logic                          step_down_button_in,
    // Save pin: strap, manual store input, end-scale indicator
    input  wire logic                          save_enable_indicator_pin_in,
    output logic                               save_enable_indicator_pin_out,
    output logic                               save_enable_indicator_pin_oe_b_out,
    // Wiper state towards the resistor string
    output logic [wsc_pkg::CODE_W-1:0]         wiper_position_register_out,
    output logic [wsc_pkg::TAPS-1:0]           tap_select_out,
    output logic                               bottom_scale_step_out,
    output logic                               top_scale_step_out,
    // Nonvolatile store
    output logic                               nv_write_out,
    output logic [wsc_pkg::CODE_W-1:0]         nv_data_out,
    output logic                               store_busy_out,
    output logic                               auto_save_mode_out
);
    import wsc_pkg::*;

    typedef struct packed {
        wsc_state_type     state;
        logic              auto_mode;
        logic [CODE_W-1:0] code;
        wsc_pos_type       pos;
        logic [CNT_W-1:0]  idle_cnt;
        logic              dirty;
        logic [CNT_W-1:0]  store_cnt;
        logic              ind;
        logic              nv_write;
        logic [CODE_W-1:0] nv_data;
        logic [TAPS-1:0]   taps;
        logic              ind_oe_b;
        logic              at_bottom;
        logic              at_top;
        logic              busy;
    } wsc_top_state_type;

    wsc_top_state_type st_reg;
    wsc_top_state_type st_next;

    wsc_deb_if up_if ();
    wsc_deb_if dn_if ();
    wsc_deb_if sv_if ();

    // Debouncers for the two buttons and the save pin
    wsc_debounce #(.ACT_HIGH(1'b1), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_up
    (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .pin_in   (step_up_button_in),
        .deb      (up_if.filt)
    );

    wsc_debounce #(.ACT_HIGH(1'b1), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_dn
    (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .pin_in   (step_down_button_in),
        .deb      (dn_if.filt)
    );

    wsc_debounce #(.ACT_HIGH(1'b0), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_sv
    (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .pin_in   (save_enable_indicator_pin_in),
        .deb      (sv_if.filt)
    );

    // One-hot tap decode of the code
    function automatic logic [TAPS-1:0] tap_decode(input logic [CODE_W-1:0] c);
        logic [TAPS-1:0] t;
        t    = '0;
        t[c] = 1'b1;
        return t;
    endfunction

    logic step_up;
    logic step_dn;
    logic any_act;

    // Synchronised button levels restart the idle timer, even bounces
    assign any_act = up_if.level | dn_if.level;

    always_comb
    begin
        st_next          = st_reg;
        st_next.nv_write = 1'b0;
        step_up          = 1'b0;
        step_dn          = 1'b0;
        case (st_reg.state)
            WSC_ST_STRAP:
            begin
                // Debounced strap is settled by the time it leaves reset level
                if (st_reg.idle_cnt < CNT_W'(DEBOUNCE_CYCLES))
                begin
                    st_next.idle_cnt = st_reg.idle_cnt + CNT_W'(1);
                end
                else
                begin
                    st_next.auto_mode = ~sv_if.level;
                    st_next.idle_cnt  = '0;
                    st_next.state     = WSC_ST_RUN;
                end
            end
            WSC_ST_RUN:
            begin
                step_up = up_if.long_pulse;
                step_dn = dn_if.long_pulse;
                // Move through bottom, codes and top
                if (step_up && !step_dn)
                begin
                    st_next.dirty = 1'b1;
                    if (st_reg.pos == WSC_POS_BOTTOM)
                    begin
                        st_next.pos  = WSC_POS_CODE;
                        st_next.code = CODE_ZERO;
                        st_next.ind  = 1'b0;
                    end
                    else if (st_reg.pos == WSC_POS_CODE && st_reg.code == CODE_FULL)
                    begin
                        st_next.pos = WSC_POS_TOP;
                    end
                    else if (st_reg.pos == WSC_POS_CODE)
                    begin
                        st_next.code = st_reg.code + CODE_W'(1);
                    end
                end
                else if (step_dn && !step_up)
                begin
                    st_next.dirty = 1'b1;
                    if (st_reg.pos == WSC_POS_TOP)
                    begin
                        st_next.pos  = WSC_POS_CODE;
                        st_next.code = CODE_FULL;
                        st_next.ind  = 1'b0;
                    end
                    else if (st_reg.pos == WSC_POS_CODE && st_reg.code == CODE_ZERO)
                    begin
                        st_next.pos = WSC_POS_BOTTOM;
                    end
                    else if (st_reg.pos == WSC_POS_CODE)
                    begin
                        st_next.code = st_reg.code - CODE_W'(1);
                    end
                end
                // Indicator at an end step while a button is held; judged on the
                // new position, else the step that leaves the end would re-arm it
                if (st_reg.auto_mode && st_next.pos != WSC_POS_CODE
                    && (up_if.active || dn_if.active))
                begin
                    st_next.ind = 1'b1;
                end
                // Released only by a step leaving the end; held through bounces
                if (!st_reg.auto_mode)
                begin
                    st_next.ind = 1'b0;
                end
                // Idle timer for auto save
                if (any_act)
                begin
                    st_next.idle_cnt = '0;
                end
                else if (st_reg.idle_cnt < CNT_W'(IDLE_SAVE_CYCLES))
                begin
                    st_next.idle_cnt = st_reg.idle_cnt + CNT_W'(1);
                end
                if (st_reg.auto_mode && st_reg.dirty && !any_act
                    && st_reg.idle_cnt >= CNT_W'(IDLE_SAVE_CYCLES))
                begin
                    st_next.state = WSC_ST_STORE;
                    st_next.dirty = 1'b0;
                end
                if (!st_reg.auto_mode && sv_if.long_pulse)
                begin
                    st_next.state = WSC_ST_STORE;
                end
                if (st_next.state == WSC_ST_STORE)
                begin
                    st_next.nv_write  = 1'b1;
                    st_next.nv_data   = st_reg.code;
                    st_next.store_cnt = '0;
                end
            end
            WSC_ST_STORE:
            begin
                // Buttons ignored; steps only taken in RUN
                if (st_reg.store_cnt < CNT_W'(STORE_CYCLES - 1))
                begin
                    st_next.store_cnt = st_reg.store_cnt + CNT_W'(1);
                end
                else
                begin
                    st_next.idle_cnt = '0;
                    st_next.state    = WSC_ST_RUN;
                end
            end
            default:
            begin
                st_next.state = WSC_ST_STRAP;
            end
        endcase
        // Tap decode registered so the select follows the code
        st_next.taps = tap_decode(st_next.code);
        // Enable and flags registered so every output leaves a flop
        st_next.ind_oe_b  = ~st_next.ind;
        st_next.at_bottom = (st_next.pos == WSC_POS_BOTTOM);
        st_next.at_top    = (st_next.pos == WSC_POS_TOP);
        st_next.busy      = (st_next.state == WSC_ST_STORE);
    end

    // Power-up code stands in for the restored nonvolatile value
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            st_reg       <= '0;
            st_reg.state <= WSC_ST_STRAP;
            st_reg.pos   <= WSC_POS_CODE;
            st_reg.code  <= POWERUP_CODE;
            st_reg.taps  <= '0;
            st_reg.ind_oe_b <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from state; pin driven high only when indicating
    assign save_enable_indicator_pin_out      = st_reg.ind;
    assign save_enable_indicator_pin_oe_b_out = st_reg.ind_oe_b;
    assign wiper_position_register_out        = st_reg.code;
    assign tap_select_out                     = st_reg.taps;
    assign bottom_scale_step_out              = st_reg.at_bottom;
    assign top_scale_step_out                 = st_reg.at_top;
    assign nv_write_out                       = st_reg.nv_write;
    assign nv_data_out                        = st_reg.nv_data;
    assign store_busy_out                     = st_reg.busy;
    assign auto_save_mode_out                 = st_reg.auto_mode;

endmodule

// ### verification/wsc_top_asserts.sv
// Purpose: Port checks for wsc_top
// Assumes: One clock, synchronous active-low reset
// Notes:   Run-length counters stand in for long repetitions
`timescale 1ns/100ps
module wsc_top_asserts
#(
    parameter int unsigned DEBOUNCE_CYCLES  = 2000,
    parameter int unsigned IDLE_SAVE_CYCLES = 200,
    parameter int unsigned STORE_CYCLES     = 20
)
(
    // Clock and reset
    input wire logic        clk_in,
    input wire logic        rst_b_in,
    // Pins
    input wire logic        step_up_button_in,
    input wire logic        step_down_button_in,
    input wire logic        save_enable_indicator_pin_out,
    input wire logic        save_enable_indicator_pin_oe_b_out,
    // Wiper and store
    input wire logic [5:0]  wiper_position_register_out,
    input wire logic [63:0] tap_select_out,
    input wire logic        bottom_scale_step_out,
    input wire logic        top_scale_step_out,
    input wire logic        nv_write_out,
    input wire logic        store_busy_out,
    input wire logic        auto_save_mode_out
);
    import wsc_pkg::*;
    logic [26:0] idle_reg;
    logic [26:0] hold_reg;
    logic [26:0] busy_reg;
    logic        btn;
    assign btn = step_up_button_in | step_down_button_in;
    // Run lengths; a short run cannot overflow 27 bits; reset avoids an unknown idle count
    always_ff @(posedge clk_in)
    begin
        idle_reg <= (btn || !rst_b_in) ? '0 : idle_reg + 1'b1;
        hold_reg <= btn ? hold_reg + 1'b1 : '0;
        busy_reg <= store_busy_out ? busy_reg + 1'b1 : '0;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    AST_TAP_ONE_HOT: assert property (
        $past(rst_b_in) |-> tap_select_out == (64'h1 << wiper_position_register_out))
        else $error("tap select wrong");
    AST_END_STEPS: assert property (
        (bottom_scale_step_out |-> !top_scale_step_out && wiper_position_register_out == 6'h00)
        and (top_scale_step_out |-> wiper_position_register_out == 6'h3f))
        else $error("end step code wrong");
    AST_IND_AUTO: assert property (
        !save_enable_indicator_pin_oe_b_out |-> auto_save_mode_out
        && save_enable_indicator_pin_out && (bottom_scale_step_out || top_scale_step_out
        || $past(bottom_scale_step_out || top_scale_step_out)))
        else $error("indicator driven wrongly");
    AST_IND_HOLD: assert property (
        $rose(save_enable_indicator_pin_oe_b_out) |-> !bottom_scale_step_out
        && !top_scale_step_out) else $error("indicator left at end step");
    AST_STORE_PULSE: assert property (
        $rose(nv_write_out) |-> store_busy_out ##1 (!nv_write_out && store_busy_out) [*8])
        else $error("store pulse wrong");
    AST_STORE_LEN: assert property (
        $fell(store_busy_out) |-> busy_reg == STORE_CYCLES) else $error("store length wrong");
    AST_AUTO_IDLE: assert property (
        nv_write_out && auto_save_mode_out |-> idle_reg >= IDLE_SAVE_CYCLES)
        else $error("auto save too early");
    AST_STEP_HOLD: assert property (
        $past(rst_b_in) && $changed(wiper_position_register_out) |-> hold_reg >= DEBOUNCE_CYCLES)
        else $error("step on short press");
endmodule

bind wsc_top wsc_top_asserts #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .IDLE_SAVE_CYCLES(IDLE_SAVE_CYCLES),
    .STORE_CYCLES(STORE_CYCLES)
) u_asserts (.clk_in, .rst_b_in, .step_up_button_in, .step_down_button_in,
    .save_enable_indicator_pin_out, .save_enable_indicator_pin_oe_b_out,
    .wiper_position_register_out, .tap_select_out, .bottom_scale_step_out,
    .top_scale_step_out, .nv_write_out, .store_busy_out, .auto_save_mode_out);

// ### verification/wsc_buttons.sv
// Purpose: Far side: two push buttons and the save pin circuit
// Assumes: Buttons have pull-downs; save pin has a pull to either rail
// Notes:   A pressed save button grounds the pin unless the device drives it
`timescale 1ns/100ps
module wsc_buttons
(
    // Bench commands
    input  wire logic rst_b_in,
    input  wire logic up_cmd_in,
    input  wire logic down_cmd_in,
    input  wire logic save_cmd_in,
    input  wire logic pull_high_in,
    // Device side of the save pin
    input  wire logic drive_in,
    input  wire logic oe_b_in,
    // Wire levels
    output logic      step_up_out,
    output logic      step_down_out,
    output logic      pin_out
);
    // Buttons held released while the device powers up
    assign step_up_out   = rst_b_in & up_cmd_in;
    assign step_down_out = rst_b_in & down_cmd_in;
    // Device drive wins; else the switch to ground, else the pull
    assign pin_out = !oe_b_in ? drive_in : (save_cmd_in ? 1'b0 : pull_high_in);
endmodule

// ### verification/wsc_top_tb.sv
// Purpose: Self-checking bench for wsc_top
// Assumes: Short idle and store counts, start code zero
// Notes:   Debounce shortened to keep the run short; bounce stays below it
`timescale 1ns/100ps
module wsc_top_tb;
    import wsc_pkg::*;
    localparam int unsigned IDLE = 200;
    localparam int unsigned DEB  = 2000;
    localparam int unsigned HOLD = DEB + 50;
    logic        clk_in, rst_b_in, up_cmd, down_cmd, save_cmd, pull_high;
    logic        up_btn, down_btn, pin_wire, pin_drv, pin_oe_b;
    logic        nv_write, busy, auto_mode, bottom;
    logic [5:0]  code, nv_data;
    logic [63:0] taps;
    int          failures, check_count;
    wsc_top #(.DEBOUNCE_CYCLES(DEB), .IDLE_SAVE_CYCLES(IDLE), .STORE_CYCLES(20),
        .POWERUP_CODE(6'h00)) dut (
        .clk_in, .rst_b_in, .step_up_button_in(up_btn), .step_down_button_in(down_btn),
        .save_enable_indicator_pin_in(pin_wire), .save_enable_indicator_pin_out(pin_drv),
        .save_enable_indicator_pin_oe_b_out(pin_oe_b), .wiper_position_register_out(code),
        .tap_select_out(taps), .bottom_scale_step_out(bottom), .top_scale_step_out(),
        .nv_write_out(nv_write), .nv_data_out(nv_data), .store_busy_out(busy),
        .auto_save_mode_out(auto_mode));
    wsc_buttons u_far (.rst_b_in, .up_cmd_in(up_cmd), .down_cmd_in(down_cmd),
        .save_cmd_in(save_cmd), .pull_high_in(pull_high), .drive_in(pin_drv),
        .oe_b_in(pin_oe_b), .step_up_out(up_btn), .step_down_out(down_btn), .pin_out(pin_wire));
    // 100 MHz clock
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // Wide enough for the joined mode, code and tap checks
    task automatic check(input logic [79:0] seen, input logic [79:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (failures == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Checks sit on the falling edge, away from register updates
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic drive(input logic u, input logic d, input logic s, input int n);
        @(posedge clk_in);
        up_cmd <= u;
        down_cmd <= d;
        save_cmd <= s;
        cyc(n);
    endtask
    // Bounded watch for a store start; a missing one ends the run
    task automatic wait_save(input int lim, input logic want);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++)
        begin
            @(negedge clk_in);
            seen = nv_write;
        end
        check(seen, want, "store start");
        if (want && !seen)
            finish_test();
    endtask
    task automatic do_reset(input logic ph);
        @(posedge clk_in);
        rst_b_in <= 1'b0;
        pull_high <= ph;
        cyc(3);
        check(taps, 64'h0, "taps in reset");
        @(posedge clk_in);
        rst_b_in <= 1'b1;
        cyc(DEB + 20);
        check({auto_mode, code, taps}, {!ph, 6'h00, 64'h1}, "after strap");
    endtask
    task automatic t_bounce();
        drive(1'b1, 1'b0, 1'b0, 1000);
        drive(1'b0, 1'b0, 1'b0, 100);
        check({bottom, code}, 7'h00, "after bounce");
    endtask
    task automatic t_bottom();
        drive(1'b0, 1'b1, 1'b0, HOLD);
        check({bottom, pin_oe_b, pin_drv, code}, {3'b101, 6'h00}, "at bottom");
        drive(1'b0, 1'b0, 1'b0, HOLD);
        check({bottom, pin_oe_b}, 2'b10, "after release");
        drive(1'b1, 1'b0, 1'b0, HOLD);
        check({bottom, pin_oe_b, code}, {2'b01, 6'h00}, "left bottom");
        drive(1'b0, 1'b0, 1'b0, 0);
    endtask
    task automatic t_autosave();
        wait_save(IDLE + 50, 1'b1);
        check(nv_data, 6'h00, "stored code");
        cyc(1);
        check(busy, 1'b1, "store busy");
        cyc(25);
        check(busy, 1'b0, "store done");
        wait_save(3 * IDLE, 1'b0);
    endtask
    task automatic t_manual();
        do_reset(1'b1);
        drive(1'b1, 1'b0, 1'b0, HOLD);
        check({code, taps}, {6'h01, 64'h2}, "after step");
        drive(1'b0, 1'b0, 1'b0, 0);
        wait_save(3 * IDLE, 1'b0);
        drive(1'b0, 1'b0, 1'b1, 500);
        drive(1'b0, 1'b0, 1'b0, 0);
        wait_save(100, 1'b0);
        drive(1'b0, 1'b0, 1'b1, 0);
        wait_save(HOLD, 1'b1);
        check(nv_data, 6'h01, "manual code");
        drive(1'b0, 1'b0, 1'b0, 1);
    endtask
    // Main sequence
    initial
    begin
        rst_b_in = 1'b0;
        up_cmd = 1'b0;
        down_cmd = 1'b0;
        save_cmd = 1'b0;
        pull_high = 1'b0;
        failures = 0;
        check_count = 0;
        do_reset(1'b0);
        t_bounce();
        t_bottom();
        t_autosave();
        t_manual();
        finish_test();
    end
endmodule
